// ===== design/pmhx_cpu.sv
`timescale 1ns/1ns
// Purpose: cpu end - apb command registers driving the parallel register port
// Assumes: apb slave with zero wait states
// Notes:   every access ends with chip select high for one cycle
module pmhx_cpu (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_irq,
	// parallel register port
	pmhx_if.cpu              bus
);
	pmhx_pkg::pmhx_seq_t seq_ff, nxt_seq;
	logic [7:0] addr_ff, wdata_ff, rdata_ff;
	logic       rd_ff, csn_ff, wrn_ff, rdn_ff, oe_ff;
	logic [1:0] scnt_ff, irqs_ff, irqm_ff;
	logic       dev_int_prev_ff;

	// apb decode
	wire        acc     = i_psel && i_penable;
	wire        wr_cmd  = acc && i_pwrite && i_paddr == pmhx_pkg::APB_CMD && seq_ff == pmhx_pkg::PMHX_IDLE;
	wire        wr_irqm = acc && i_pwrite && i_paddr == pmhx_pkg::APB_IRQM;
	wire        rd_irqs = acc && !i_pwrite && i_paddr == pmhx_pkg::APB_IRQS;
	wire        busy    = seq_ff != pmhx_pkg::PMHX_IDLE;
	wire        rd_next = wr_cmd ? i_pwdata[pmhx_pkg::CMD_RD_BIT] : rd_ff; // direction of the access being set up
	wire        fin     = seq_ff == pmhx_pkg::PMHX_REL;
	wire        dev_int = !bus.interrupt_out_n && dev_int_prev_ff;
	wire [1:0]  ev_set  = {dev_int, fin};
	wire [31:0] rmux    =
		(i_paddr == pmhx_pkg::APB_CMD)  ? {15'h0000, rd_ff, addr_ff, wdata_ff} :
		(i_paddr == pmhx_pkg::APB_STAT) ? {16'h0000, rdata_ff, 7'h00, busy} :
		(i_paddr == pmhx_pkg::APB_IRQS) ? {30'h0, irqs_ff} :
		(i_paddr == pmhx_pkg::APB_IRQM) ? {30'h0, irqm_ff} : 32'h0;

	// parallel bus sequence: setup, strobe, hold, release
	always_comb begin
		nxt_seq = seq_ff;
		unique case (seq_ff)
			pmhx_pkg::PMHX_IDLE:  if (wr_cmd) nxt_seq = pmhx_pkg::PMHX_SETUP;
			pmhx_pkg::PMHX_SETUP: nxt_seq = pmhx_pkg::PMHX_STRB;
			pmhx_pkg::PMHX_STRB:  if (scnt_ff == 2'(pmhx_pkg::STRB_CYC - 1)) nxt_seq = pmhx_pkg::PMHX_HOLD;
			pmhx_pkg::PMHX_HOLD:  nxt_seq = pmhx_pkg::PMHX_REL;
			pmhx_pkg::PMHX_REL:   nxt_seq = pmhx_pkg::PMHX_IDLE;
			default:              nxt_seq = pmhx_pkg::PMHX_IDLE;
		endcase
	end

	// sequencer and pin registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			seq_ff  <= pmhx_pkg::PMHX_IDLE;
			scnt_ff <= 2'h0;
			csn_ff  <= 1'b1;
			wrn_ff  <= 1'b1;
			rdn_ff  <= 1'b1;
			oe_ff   <= 1'b0;
		end else begin
			seq_ff  <= nxt_seq;
			scnt_ff <= (nxt_seq == pmhx_pkg::PMHX_STRB && seq_ff == pmhx_pkg::PMHX_STRB) ? scnt_ff + 2'h1 : 2'h0;
			csn_ff  <= !(nxt_seq inside {pmhx_pkg::PMHX_SETUP, pmhx_pkg::PMHX_STRB, pmhx_pkg::PMHX_HOLD});
			wrn_ff  <= !(nxt_seq == pmhx_pkg::PMHX_STRB && !rd_ff);
			rdn_ff  <= !(nxt_seq == pmhx_pkg::PMHX_STRB && rd_ff);
			oe_ff   <= nxt_seq inside {pmhx_pkg::PMHX_SETUP, pmhx_pkg::PMHX_STRB} && !rd_next;
		end
	end

	// command, data, interrupt status (read clears, set wins) and apb read data
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			addr_ff         <= 8'h00;
			wdata_ff        <= 8'h00;
			rd_ff           <= 1'b0;
			rdata_ff        <= 8'h00;
			irqs_ff         <= 2'h0;
			irqm_ff         <= 2'h0;
			dev_int_prev_ff <= 1'b1;
			o_irq           <= 1'b0;
		end else begin
			if (wr_cmd) begin
				wdata_ff <= i_pwdata[7:0];
				addr_ff  <= i_pwdata[15:8];
				rd_ff    <= i_pwdata[pmhx_pkg::CMD_RD_BIT];
			end
			if (seq_ff == pmhx_pkg::PMHX_STRB && nxt_seq == pmhx_pkg::PMHX_HOLD && rd_ff) begin
				rdata_ff <= bus.dev_data;
			end
			if (wr_irqm) begin
				irqm_ff <= i_pwdata[1:0];
			end
			dev_int_prev_ff <= bus.interrupt_out_n;
			irqs_ff         <= (rd_irqs ? 2'h0 : irqs_ff) | ev_set;
			o_irq           <= |(irqs_ff & irqm_ff);
		end
	end

	assign o_prdata        = rmux;
	assign o_pready        = 1'b1;
	assign o_pslverr       = 1'b0;
	assign bus.chip_select_n = csn_ff;
	assign bus.wr_n        = wrn_ff;
	assign bus.rd_n        = rdn_ff;
	assign bus.addr        = addr_ff;
	assign bus.cpu_data    = wdata_ff;
	assign bus.cpu_data_oe = oe_ff;
endmodule // pmhx_cpu

// ===== design/pmhx_dev.sv
`timescale 1ns/1ns
// Purpose: device end - power management and host transceiver control registers
// Assumes: parallel port sampled on i_clk_sys, oscillator activity given as a level
// Notes:   register writes commit when the write strobe ends
// What this block does
// - cpu cut request in sleep lowers power
// - cut mode ignores all port inputs but chip select
// - dummy read of power control ends cut
// - cpu releases chip select after dummy read
// - synchronous interrupts masked while asleep
// - firmware clears sync status around sleep
// - power state reads 00, 01, 11
// - power state passes intermediate values
// - wake loads 16-bit settle count, oscillator on
// - count end opens oscillator clock gate
// - wake-up time registers reachable in sleep
// - software keeps total wake within 5.1 ms
// - vbus enable bit drives pin, default low
// - termination select 0 hs, 1 fs
// - pull-down disable 0 on, 1 off
// - transceiver select 00 hs, 01 fs, 11 ls
// - operating mode decodes four transceiver modes
// - requests self-clear and done flag sets together
module pmhx_dev #(
	parameter int PLL_CYC = pmhx_pkg::PLL_SETTLE_CYC
) (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	// parallel register port
	pmhx_if.dev             bus,
	// oscillator and pll
	input  wire logic       i_osc_toggling,
	output logic            o_osc_enable,
	output logic            o_osc_clock_gate,
	output logic            o_pll_enable,
	output logic            o_cpu_if_off,
	// events and automatic negotiation
	input  wire logic       i_sync_event,
	input  wire logic       i_hw_auto_config,
	input  wire logic       i_auto_term,
	input  wire logic [1:0] i_auto_xsel,
	input  wire logic [1:0] i_auto_xcvr_operating_mode,
	// transceiver controls
	output logic            o_vbus_enable_pin,
	output logic            o_termination_select,
	output logic            o_pulldown_disable,
	output logic [1:0]      o_transceiver_select,
	output logic [1:0]      o_xcvr_operating_mode,
	output logic            o_xcvr_nondrive,
	output logic            o_xcvr_raw,
	output logic            o_xcvr_pwrdn
);
	pmhx_pkg::pmhx_pwr_t state_ff, nxt_state;
	logic        cut_ff, wr_ff, rd_ff, cut_cs_ff;
	logic [7:0]  addr_ff, data_ff;
	logic        sleep_req_ff, wake_req_ff;
	logic [15:0] wk_ff, cnt_ff, nxt_cnt;
	logic [31:0] pll_ff, nxt_pll;
	logic [7:0]  vbc_ff, xcc_ff, nxt_xcc;
	logic [1:0]  evf_ff, evm_ff;
	logic        done, int_n_ff;
	logic [7:0]  rdata_ff;
	logic        rdoe_ff;

	// port decode; in cut mode only chip select is seen
	wire       acc     = !bus.chip_select_n && !cut_ff;
	wire       wr_now  = acc && !bus.wr_n;
	wire       rd_now  = acc && !bus.rd_n;
	wire       wr_end  = wr_ff && !wr_now;
	wire       rd_end  = rd_ff && !rd_now;
	wire       wr_pmc  = wr_end && addr_ff == pmhx_pkg::PMC_OFS;
	wire       wr_wkh  = wr_end && addr_ff == pmhx_pkg::WKH_OFS;
	wire       wr_wkl  = wr_end && addr_ff == pmhx_pkg::WKL_OFS;
	wire       wr_vbc  = wr_end && addr_ff == pmhx_pkg::VBC_OFS;
	wire       wr_xcc  = wr_end && addr_ff == pmhx_pkg::XCC_OFS;
	wire       wr_evm  = wr_end && addr_ff == pmhx_pkg::EVM_OFS;
	wire       rd_evf  = rd_end && addr_ff == pmhx_pkg::EVF_OFS;
	wire       asleep  = state_ff != pmhx_pkg::PMHX_ACTIVE;
	wire       cut_go  = wr_pmc && data_ff[pmhx_pkg::CUT_BIT] && state_ff == pmhx_pkg::PMHX_OFF;
	wire       cut_end = cut_ff && cut_cs_ff && bus.chip_select_n;
	wire [1:0] ev_set  = {i_sync_event, done};
	wire [1:0] ev_live = evf_ff & evm_ff & {!asleep, 1'b1};

	// power state code; intermediate states read as 01
	wire [1:0] pstate = (state_ff == pmhx_pkg::PMHX_ACTIVE) ? pmhx_pkg::PS_ACTIVE :
		(state_ff == pmhx_pkg::PMHX_OFF) ? pmhx_pkg::PS_SLEEP : pmhx_pkg::PS_SNOOZE;

	// read data selection; reserved bits are zero
	wire [7:0] pmc_rd = {sleep_req_ff, wake_req_ff, 4'h0, pstate};
	wire [7:0] xcc_rd = {xcc_ff[7:4], 2'h0, xcc_ff[1:0]};
	wire [7:0] cur_addr = rd_now ? bus.addr : addr_ff; // live address on the first strobe cycle
	wire [7:0] rmux   =
		(cur_addr == pmhx_pkg::PMC_OFS) ? pmc_rd :
		(cur_addr == pmhx_pkg::WKH_OFS) ? wk_ff[15:8] :
		(cur_addr == pmhx_pkg::WKL_OFS) ? wk_ff[7:0] :
		(cur_addr == pmhx_pkg::VBC_OFS) ? {vbc_ff[7], 7'h00} :
		(cur_addr == pmhx_pkg::XCC_OFS) ? xcc_rd :
		(cur_addr == pmhx_pkg::EVF_OFS) ? {6'h00, evf_ff} :
		(cur_addr == pmhx_pkg::EVM_OFS) ? {6'h00, evm_ff} : 8'h00;

	// transceiver control: hardware owns fields in automatic mode
	always_comb begin
		nxt_xcc = xcc_ff;
		if (wr_xcc) nxt_xcc = data_ff & 8'hf3;
		if (i_hw_auto_config) begin
			nxt_xcc[pmhx_pkg::TERM_BIT] = i_auto_term;
			nxt_xcc[pmhx_pkg::XSEL_LSB +: 2] = i_auto_xsel;
			nxt_xcc[pmhx_pkg::OPM_LSB +: 2] = i_auto_xcvr_operating_mode;
		end
	end

	// power sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_pll   = pll_ff;
		done      = 1'b0;
		unique case (state_ff)
			pmhx_pkg::PMHX_OFF: begin
				if (wake_req_ff) begin
					nxt_state = pmhx_pkg::PMHX_OSC_WAIT;
					nxt_cnt   = wk_ff;
				end else if (sleep_req_ff) begin
					done = 1'b1;
				end
			end
			pmhx_pkg::PMHX_OSC_WAIT: begin
				if (i_osc_toggling) begin
					if (cnt_ff == 16'h0000) begin
						nxt_state = pmhx_pkg::PMHX_PLL_WAIT;
						nxt_pll   = 32'(PLL_CYC - 1);
					end else begin
						nxt_cnt = cnt_ff - 16'h0001;
					end
				end
			end
			pmhx_pkg::PMHX_PLL_WAIT: begin
				if (pll_ff == 32'h0) begin
					nxt_state = pmhx_pkg::PMHX_ACTIVE;
					done      = 1'b1;
				end else begin
					nxt_pll = pll_ff - 32'h1;
				end
			end
			pmhx_pkg::PMHX_ACTIVE: begin
				if (sleep_req_ff) begin
					nxt_state = pmhx_pkg::PMHX_PLL_STOP;
				end else if (wake_req_ff) begin
					done = 1'b1;
				end
			end
			pmhx_pkg::PMHX_PLL_STOP: begin
				nxt_state = pmhx_pkg::PMHX_OFF;
				done      = 1'b1;
			end
			default: begin
				nxt_state = pmhx_pkg::PMHX_OFF;
			end
		endcase
	end

	// sequencer registers and derived clock controls
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_ff         <= pmhx_pkg::PMHX_OFF;
			cnt_ff           <= 16'h0000;
			pll_ff           <= 32'h0;
			o_osc_enable     <= 1'b0;
			o_osc_clock_gate <= 1'b0;
			o_pll_enable     <= 1'b0;
		end else begin
			state_ff         <= nxt_state;
			cnt_ff           <= nxt_cnt;
			pll_ff           <= nxt_pll;
			o_osc_enable     <= nxt_state != pmhx_pkg::PMHX_OFF;
			o_osc_clock_gate <= nxt_state inside {pmhx_pkg::PMHX_PLL_WAIT, pmhx_pkg::PMHX_ACTIVE};
			o_pll_enable     <= nxt_state inside {pmhx_pkg::PMHX_PLL_WAIT, pmhx_pkg::PMHX_ACTIVE};
		end
	end

	// port capture and cut mode
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wr_ff        <= 1'b0;
			rd_ff        <= 1'b0;
			cut_cs_ff    <= 1'b0;
			addr_ff      <= 8'h00;
			data_ff      <= 8'h00;
			cut_ff       <= 1'b0;
			o_cpu_if_off <= 1'b0;
		end else begin
			wr_ff       <= wr_now;
			rd_ff       <= rd_now;
			cut_cs_ff   <= cut_ff && !cut_end && (cut_cs_ff || !bus.chip_select_n); // skip the setting release
			addr_ff     <= cur_addr;
			if (wr_now) begin
				addr_ff <= bus.addr;
				data_ff <= bus.cpu_data;
			end
			if (cut_go || cut_end) begin
				cut_ff       <= cut_go;
				o_cpu_if_off <= cut_go;
			end
		end
	end

	// control registers; request set wins over completion clear
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sleep_req_ff <= 1'b0;
			wake_req_ff  <= 1'b0;
			wk_ff        <= pmhx_pkg::WK_RST;
			vbc_ff       <= pmhx_pkg::VBC_RST;
			xcc_ff       <= pmhx_pkg::XCC_RST;
			evm_ff       <= 2'h0;
		end else begin
			if (done) begin
				sleep_req_ff <= 1'b0;
				wake_req_ff  <= 1'b0;
			end
			if (wr_pmc && data_ff[pmhx_pkg::SLEEP_BIT]) sleep_req_ff <= 1'b1;
			if (wr_pmc && data_ff[pmhx_pkg::WAKE_BIT]) wake_req_ff <= 1'b1;
			if (wr_wkh) wk_ff[15:8] <= data_ff;
			if (wr_wkl) wk_ff[7:0] <= data_ff;
			if (wr_vbc) vbc_ff <= {data_ff[pmhx_pkg::VBUS_BIT], 7'h00};
			if (wr_evm) evm_ff <= data_ff[1:0];
			xcc_ff <= nxt_xcc;
		end
	end

	// event flags (read clears, set wins), interrupt and read data
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			evf_ff   <= 2'h0;
			int_n_ff <= 1'b1;
			rdata_ff <= 8'h00;
			rdoe_ff  <= 1'b0;
		end else begin
			evf_ff   <= ((rd_evf ? 2'h0 : evf_ff) | ev_set);
			int_n_ff <= !(|ev_live);
			rdoe_ff  <= rd_now;
			if (rd_now || rd_ff) rdata_ff <= rmux;
		end
	end

	// transceiver pins from register fields
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_vbus_enable_pin     <= 1'b0;
			o_termination_select  <= 1'b1;
			o_pulldown_disable    <= 1'b0;
			o_transceiver_select  <= 2'h1;
			o_xcvr_operating_mode <= 2'h1;
			o_xcvr_nondrive       <= 1'b1;
			o_xcvr_raw            <= 1'b0;
			o_xcvr_pwrdn          <= 1'b0;
		end else begin
			o_vbus_enable_pin     <= vbc_ff[pmhx_pkg::VBUS_BIT];
			o_termination_select  <= xcc_ff[pmhx_pkg::TERM_BIT];
			o_pulldown_disable    <= xcc_ff[pmhx_pkg::RPD_BIT];
			o_transceiver_select  <= xcc_ff[pmhx_pkg::XSEL_LSB +: 2];
			o_xcvr_operating_mode <= xcc_ff[pmhx_pkg::OPM_LSB +: 2];
			o_xcvr_nondrive       <= xcc_ff[1:0] == pmhx_pkg::OPM_NODRV || xcc_ff[1:0] == pmhx_pkg::OPM_PDN;
			o_xcvr_raw            <= xcc_ff[1:0] == pmhx_pkg::OPM_RAW;
			o_xcvr_pwrdn          <= xcc_ff[1:0] == pmhx_pkg::OPM_PDN;
		end
	end

	assign bus.dev_data        = rdata_ff;
	assign bus.dev_data_oe     = rdoe_ff;
	assign bus.interrupt_out_n = int_n_ff;
endmodule // pmhx_dev

// ===== design/pmhx_if.sv
`timescale 1ns/1ns
// Purpose: parallel register port between cpu end and device end
// Assumes: all signals synchronous to the system clock
// Notes:   data bus split into per-side data and enable
interface pmhx_if;
	logic       chip_select_n;
	logic       wr_n;
	logic       rd_n;
	logic [7:0] addr;
	logic [7:0] cpu_data;
	logic       cpu_data_oe;
	logic [7:0] dev_data;
	logic       dev_data_oe;
	logic       interrupt_out_n;
	modport dev (input chip_select_n, wr_n, rd_n, addr, cpu_data, cpu_data_oe,
		output dev_data, dev_data_oe, interrupt_out_n);
	modport cpu (output chip_select_n, wr_n, rd_n, addr, cpu_data, cpu_data_oe,
		input dev_data, dev_data_oe, interrupt_out_n);
endinterface

// ===== design/pmhx_pkg.sv
// Purpose: shared constants and types for the power / host transceiver register block
// Assumes: 100 MHz system clock, 8-bit parallel register port
// Notes:   offsets are byte addresses on the parallel port and on apb
package pmhx_pkg;
	// parallel port register offsets
	localparam logic [7:0] EVF_OFS = 8'h08;
	localparam logic [7:0] EVM_OFS = 8'h09;
	localparam logic [7:0] PMC_OFS = 8'h12;
	localparam logic [7:0] WKH_OFS = 8'h14;
	localparam logic [7:0] WKL_OFS = 8'h15;
	localparam logic [7:0] VBC_OFS = 8'h16;
	localparam logic [7:0] XCC_OFS = 8'h17;
	// field positions
	localparam int SLEEP_BIT = 7;
	localparam int WAKE_BIT  = 6;
	localparam int CUT_BIT   = 5;
	localparam int VBUS_BIT  = 7;
	localparam int TERM_BIT  = 7;
	localparam int RPD_BIT   = 6;
	localparam int XSEL_LSB  = 4;
	localparam int OPM_LSB   = 0;
	localparam int EV_DONE   = 0;
	localparam int EV_SYNC   = 1;
	// reset values
	localparam logic [7:0]  VBC_RST = 8'h00;
	localparam logic [7:0]  XCC_RST = 8'h91;
	localparam logic [15:0] WK_RST  = 16'h0000;
	// power state codes
	localparam logic [1:0] PS_SLEEP  = 2'h0;
	localparam logic [1:0] PS_SNOOZE = 2'h1;
	localparam logic [1:0] PS_ACTIVE = 2'h3;
	// operating mode codes
	localparam logic [1:0] OPM_NODRV = 2'h1;
	localparam logic [1:0] OPM_RAW   = 2'h2;
	localparam logic [1:0] OPM_PDN   = 2'h3;
	// timing
	localparam int CLK_MHZ       = 100;
	localparam int PLL_SETTLE_US = 250;
	localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
	localparam int STRB_CYC      = 2;
	// apb offsets of the controller end
	localparam logic [7:0] APB_CMD  = 8'h00;
	localparam logic [7:0] APB_STAT = 8'h04;
	localparam logic [7:0] APB_IRQS = 8'h08;
	localparam logic [7:0] APB_IRQM = 8'h0c;
	localparam int CMD_RD_BIT = 16;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_DEV    = 1;
	// power sequencer states
	typedef enum logic [2:0] {PMHX_OFF, PMHX_OSC_WAIT, PMHX_PLL_WAIT, PMHX_ACTIVE, PMHX_PLL_STOP} pmhx_pwr_t;
	// parallel bus sequencer states
	typedef enum logic [2:0] {PMHX_IDLE, PMHX_SETUP, PMHX_STRB, PMHX_HOLD, PMHX_REL} pmhx_seq_t;
endpackage

// ===== testbench/pmhx_monitor.sv
`timescale 1ns/1ns
// Purpose: protocol checks on the parallel register port
// Assumes: one clock domain, synchronous active high reset
// Notes:   sees only the interface signals between both ends
module pmhx_monitor (
	// clock and reset
	input wire logic       i_clk_sys,
	input wire logic       i_sys_rst,
	// parallel register port
	input wire logic       chip_select_n,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] cpu_data,
	input wire logic       cpu_data_oe,
	input wire logic [7:0] dev_data,
	input wire logic       dev_data_oe,
	input wire logic       interrupt_out_n
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// only one end drives the data lines
	a_no_bus_fight: assert property (!(dev_data_oe && cpu_data_oe))
		else $error("data lines driven by both ends");
	// a strobe needs chip select and never comes with the other strobe
	a_strobe_in_cs: assert property ((!wr_n || !rd_n) |-> !chip_select_n && (wr_n || rd_n))
		else $error("strobe outside chip select");
	// setup cycle is followed by a strobe
	a_setup_first: assert property ($fell(chip_select_n) |=> (!wr_n || !rd_n))
		else $error("no strobe after setup cycle");
	// write strobe lasts two cycles with address and data held
	a_write_held: assert property ($fell(wr_n) |-> cpu_data_oe ##1 (!wr_n && $stable(addr) && $stable(cpu_data)) ##1 wr_n)
		else $error("write strobe or data not held");
	// read strobe lasts two cycles
	a_read_two: assert property ($fell(rd_n) |=> !rd_n ##1 rd_n)
		else $error("read strobe length wrong");
	// one hold cycle, then chip select released
	a_cs_release: assert property (($rose(rd_n) || $rose(wr_n)) |=> $rose(chip_select_n))
		else $error("chip select not released after hold");
	// device answers a read one cycle after the strobe
	a_read_answer: assert property ($rose(dev_data_oe) |-> $past(rd_n) == 1'b0 && !chip_select_n)
		else $error("read data not caused by a read strobe");
	// device quiet on the data lines outside accesses
	a_idle_quiet: assert property ((chip_select_n && $past(chip_select_n)) |-> !dev_data_oe)
		else $error("device drives data while deselected");
	// no interrupt and no data drive right after reset
	a_reset_quiet: assert property ($fell(i_sys_rst) |-> interrupt_out_n && chip_select_n && !dev_data_oe)
		else $error("port not idle after reset");
endmodule // pmhx_monitor

// ===== testbench/tb.sv
`timescale 1ns/1ns
// Purpose: bench for both ends joined by the parallel register port
// Assumes: cpu end reached over apb, short pll settle in simulation
// Notes:   all parallel accesses go through the cpu end command register
module tb;
	localparam int PLL = 8;
	logic        i_clk_sys = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, irq;
	logic        osc_tog = 1'b0, sync_ev = 1'b0, auto_cfg = 1'b0, auto_term = 1'b0;
	logic [1:0]  auto_xsel = 2'h3, auto_opm = 2'h2, xsel, opm;
	logic        osc_en, osc_gate, pll_en, cut, vbus, term, rpd, nondrv, raw, pwrdn;
	logic [7:0]  ofs [5] = '{pmhx_pkg::WKH_OFS, pmhx_pkg::WKL_OFS, pmhx_pkg::VBC_OFS, pmhx_pkg::XCC_OFS, pmhx_pkg::PMC_OFS};
	logic [7:0]  rexp [5] = '{pmhx_pkg::WK_RST[15:8], pmhx_pkg::WK_RST[7:0], pmhx_pkg::VBC_RST, pmhx_pkg::XCC_RST, 8'h00};
	int          failures = 0, checks_done = 0, cycles = 0;
	// joined ends and port checker
	pmhx_if bus_if ();
	pmhx_dev #(.PLL_CYC(PLL)) i_pmhx_dev (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .bus(bus_if),
		.i_osc_toggling(osc_tog), .o_osc_enable(osc_en), .o_osc_clock_gate(osc_gate), .o_pll_enable(pll_en),
		.o_cpu_if_off(cut), .i_sync_event(sync_ev), .i_hw_auto_config(auto_cfg), .i_auto_term(auto_term),
		.i_auto_xsel(auto_xsel), .i_auto_xcvr_operating_mode(auto_opm), .o_vbus_enable_pin(vbus), .o_termination_select(term),
		.o_pulldown_disable(rpd), .o_transceiver_select(xsel), .o_xcvr_operating_mode(opm),
		.o_xcvr_nondrive(nondrv), .o_xcvr_raw(raw), .o_xcvr_pwrdn(pwrdn));
	pmhx_cpu i_pmhx_cpu (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .bus(bus_if));
	pmhx_monitor i_pmhx_monitor (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.chip_select_n(bus_if.chip_select_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .addr(bus_if.addr),
		.cpu_data(bus_if.cpu_data), .cpu_data_oe(bus_if.cpu_data_oe), .dev_data(bus_if.dev_data),
		.dev_data_oe(bus_if.dev_data_oe), .interrupt_out_n(bus_if.interrupt_out_n));
	// clock
	always #5 i_clk_sys = ~i_clk_sys;
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one apb transfer, read data into rd
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		@(posedge i_clk_sys);
		while (pready !== 1'b1) @(posedge i_clk_sys);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// parallel access through the command register, waits for busy low
	task automatic par(input logic rdop, input logic [7:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, pmhx_pkg::APB_CMD, {15'h0, rdop, a, d});
		n = 0;
		do begin
			apb(1'b0, pmhx_pkg::APB_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 50);
	endtask
	task automatic wrp(input logic [7:0] a, input logic [7:0] d);
		par(1'b0, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] want);
		par(1'b1, a, 8'h00);
		chk(rd[15:8], want);
	endtask
	// hang guard
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		int n;
		repeat (8) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		chk({vbus, term, rpd, xsel, opm, nondrv, osc_en, osc_gate, cut, irq}, 12'b0_1_0_01_01_1_0_0_0_0);
		for (int i = 0; i < 5; i++) rdc(ofs[i], rexp[i]);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chk({pready, pslverr}, 2'b10);
		apb(1'b1, pmhx_pkg::APB_IRQM, 32'h2);
		wrp(pmhx_pkg::EVM_OFS, 8'h03);
		// command while busy is dropped
		apb(1'b1, pmhx_pkg::APB_CMD, {16'h0, pmhx_pkg::VBC_OFS, 8'h00});
		wrp(pmhx_pkg::VBC_OFS, 8'hff);
		rdc(pmhx_pkg::VBC_OFS, 8'h00);
		wrp(pmhx_pkg::VBC_OFS, 8'hff);
		rdc(pmhx_pkg::VBC_OFS, 8'h80);
		chk(vbus, 1'b1);
		wrp(pmhx_pkg::XCC_OFS, 8'hff);
		rdc(pmhx_pkg::XCC_OFS, 8'hf3);
		chk({term, rpd, xsel, opm, pwrdn}, 7'b1_1_11_11_1);
		for (int i = 0; i < 4; i++) begin
			wrp(pmhx_pkg::XCC_OFS, 8'(i));
			chk({term, xsel, opm, nondrv, raw, pwrdn}, {3'b000, 2'(i), i[0], i == 2, i == 3});
		end
		// hardware owned fields
		auto_cfg <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		rdc(pmhx_pkg::XCC_OFS, 8'h32);
		chk({term, xsel, raw}, 4'b0_11_1);
		auto_cfg <= 1'b0;
		wrp(pmhx_pkg::XCC_OFS, 8'h91);
		// wake with settle count 8, sync event masked while asleep
		wrp(pmhx_pkg::WKH_OFS, 8'h00);
		wrp(pmhx_pkg::WKL_OFS, 8'h08);
		rdc(pmhx_pkg::WKL_OFS, 8'h08);
		sync_ev <= 1'b1;
		@(posedge i_clk_sys);
		sync_ev <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		chk(bus_if.interrupt_out_n, 1'b1);
		wrp(pmhx_pkg::PMC_OFS, 8'h40);
		rdc(pmhx_pkg::PMC_OFS, 8'h41);
		chk({osc_en, osc_gate, pll_en}, 3'b100);
		osc_tog <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		chk(osc_gate, 1'b0);
		n = 0;
		while (osc_gate !== 1'b1 && n < 20) begin
			@(posedge i_clk_sys);
			n++;
		end
		chk(osc_gate, 1'b1);
		repeat (PLL + 5) @(posedge i_clk_sys);
		rdc(pmhx_pkg::PMC_OFS, 8'h03);
		chk({bus_if.interrupt_out_n, irq}, 2'b01);
		rdc(pmhx_pkg::EVF_OFS, 8'h03);
		repeat (3) @(posedge i_clk_sys);
		chk(bus_if.interrupt_out_n, 1'b1);
		apb(1'b0, pmhx_pkg::APB_IRQS, 32'h0);
		chk(rd, 32'h3);
		repeat (2) @(posedge i_clk_sys);
		chk(irq, 1'b0);
		// back to sleep
		wrp(pmhx_pkg::PMC_OFS, 8'h80);
		repeat (4) @(posedge i_clk_sys);
		rdc(pmhx_pkg::PMC_OFS, 8'h00);
		chk({osc_en, pll_en}, 2'b00);
		rdc(pmhx_pkg::EVF_OFS, 8'h01);
		// cut mode: a write is ignored and its release ends the mode
		wrp(pmhx_pkg::PMC_OFS, 8'h20);
		chk(cut, 1'b1);
		wrp(pmhx_pkg::VBC_OFS, 8'h00);
		chk(cut, 1'b0);
		rdc(pmhx_pkg::VBC_OFS, 8'h80);
		// cut mode left by a dummy read
		wrp(pmhx_pkg::PMC_OFS, 8'h20);
		chk(cut, 1'b1);
		par(1'b1, pmhx_pkg::PMC_OFS, 8'h00);
		chk(cut, 1'b0);
		stop_test();
	end
endmodule // tb
